/* src/uar_pkg.sv */
// Package of register map, field positions and timing for the serial port with address match.
package uar_pkg;
  localparam logic [7:0] SERIAL_CONTROL_ADDR    = 8'h98;
  localparam logic [7:0] SERIAL_DATA_ADDR       = 8'h99;
  localparam logic [7:0] NODE_ADDRESS_ADDR      = 8'hA9;
  localparam logic [7:0] NODE_ADDRESS_MASK_ADDR = 8'hB9;
  localparam logic [7:0] FRAMING_CTRL_ADDR      = 8'hC1;
  localparam logic [7:0] IRQ_STATUS_ADDR        = 8'hC2;
  localparam logic [7:0] IRQ_MASK_ADDR          = 8'hC3;
  localparam logic [7:0] BAUD_DIV_ADDR          = 8'hC4;
  localparam int BIT_FLAG_MODE_LOW = 7;
  localparam int BIT_MODE_HIGH     = 6;
  localparam int BIT_MPE      = 5;
  localparam int BIT_REN      = 4;
  localparam int BIT_TX_NINTH = 3;
  localparam int BIT_RX_NINTH = 2;
  localparam int BIT_TDONE    = 1;
  localparam int BIT_RDONE    = 0;
  localparam int BIT_FSEL     = 0;
  localparam int IRQ_RX       = 0;
  localparam int IRQ_TX       = 1;
  localparam int IRQ_FRAME    = 2;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] ADDR_RESET    = 8'h00;
  localparam logic [7:0] MASK_RESET    = 8'h00;
  localparam logic [7:0] DIV_RESET     = 8'h0F;
  localparam logic [1:0] MODE_SHIFT    = 2'h0;
  localparam logic [1:0] MODE_UART8    = 2'h1;
  localparam logic [1:0] MODE_UART9F   = 2'h2;
  localparam logic [1:0] MODE_UART9V   = 2'h3;
  typedef enum logic [1:0] {UAR_IDLE, UAR_START, UAR_DATA, UAR_STOP} uar_state_t;
endpackage

/* src/uar_top.sv */
// Serial port with framing error flag, automatic address recognition and interrupt.
// Operation
// - Framing error flag stays set until software write or reset.
// - With framing checking enabled, receive-done rises at the stop bit.
// - Address recognition active when multiproc_enable is set, except in shift-register mode.
// - With recognition, receive-done set only for own address frames.
// - In 8-bit variable mode, stop bit serves as address marker.
// - 8-bit mode with recognition needs address match and valid stop bit.
// - Accept only given address from address and mask; no broadcast address formed.
// - In shift-register mode multiproc_enable has no effect.
// - Address and mask reset to zero, so every address matches.
// - Address and mask reset to zero, byte access only.
// - multiproc_enable filters in both 9-bit modes and 8-bit variable mode.
// - 9-bit modes load received ninth bit into its field.
// - 8-bit mode without filtering stores stop bit in ninth-bit field.
// - Transmit-done at end of eighth bit in mode 0, else at stop start.
`timescale 1ns/10ps
`default_nettype none
module uar_top
  import uar_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       rxd,
  output logic            txd,
  output logic            irq
);
  import uar_pkg::*;

  logic [7:0] ctrl_r;
  logic       frame_err_r;
  logic       fsel_r;
  logic       mode_low_r;
  logic [7:0] node_address_r;
  logic [7:0] node_address_mask_r;
  logic [7:0] rx_data_r;
  logic [7:0] div_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic [1:0] mode;
  uar_state_t rx_state_r;
  uar_state_t tx_state_r;
  logic [7:0] rx_cnt_r;
  logic [3:0] rx_bit_r;
  logic [8:0] rx_shift_r;
  logic [7:0] tx_cnt_r;
  logic [3:0] tx_bit_r;
  logic [8:0] tx_shift_r;
  logic       rx_done_pulse;
  logic       tx_done_pulse;
  logic       frame_err_pulse;
  logic       rx_last_data;
  logic       rx_tick;
  logic       tx_tick;
  logic [3:0] data_bits;
  logic       filter_on;
  logic       addr_ok;
  logic       marker;
  logic       wr_ctrl;

  function automatic logic addr_match(input logic [7:0] rx, input logic [7:0] a,
                                      input logic [7:0] m);
    addr_match = (((rx ^ a) & m) == 8'h00);
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] which);
    hit = (a == which);
  endfunction

  assign mode      = {mode_low_r, ctrl_r[BIT_MODE_HIGH]};
  assign data_bits = (mode[1]) ? 4'h9 : 4'h8;
  assign rx_tick   = (rx_cnt_r == 8'h00);
  assign tx_tick   = (tx_cnt_r == 8'h00);
  assign wr_ctrl   = reg_wr && hit(reg_addr, SERIAL_CONTROL_ADDR);
  // Filtering is dead in shift mode whatever software writes.
  assign filter_on = ctrl_r[BIT_MPE] && (mode != MODE_SHIFT);
  // Given address: mask bits of zero are don't-care, so any address passes after reset.
  assign addr_ok   = addr_match(rx_shift_r[7:0], node_address_r, node_address_mask_r);
  // Marker is ninth bit in 9-bit modes, stop bit in 8-bit mode.
  assign marker    = (mode == MODE_UART8) ? rxd : rx_shift_r[8];
  assign rx_last_data = (rx_state_r == UAR_DATA) && rx_tick && (rx_bit_r == data_bits - 4'h1);

  always_comb begin
    rx_done_pulse = 1'b0;
    frame_err_pulse = 1'b0;
    if ((rx_state_r == UAR_STOP) && rx_tick) begin
      frame_err_pulse = !rxd;
      if (!filter_on) begin
        rx_done_pulse = fsel_r || (mode == MODE_SHIFT);
      end else if (mode == MODE_UART8) begin
        rx_done_pulse = rxd && addr_ok;
      end else begin
        rx_done_pulse = marker && addr_ok && (fsel_r ? rxd : 1'b1);
      end
    end
    if (rx_last_data && !fsel_r && !filter_on && (mode != MODE_SHIFT)) begin
      rx_done_pulse = 1'b1;
    end
    if (rx_last_data && (mode == MODE_SHIFT)) begin
      rx_done_pulse = 1'b1;
    end
  end

  always_comb begin
    tx_done_pulse = 1'b0;
    if (mode == MODE_SHIFT) begin
      tx_done_pulse = (tx_state_r == UAR_DATA) && tx_tick && (tx_bit_r == 4'h7);
    end else begin
      tx_done_pulse = (tx_state_r == UAR_DATA) && tx_tick &&
                      (tx_bit_r == data_bits - 4'h1);
    end
  end

  // Control bits; hardware sets of the done flags win over a software clear.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r     <= CONTROL_RESET;
      mode_low_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= reg_wdata;
        if (!fsel_r) begin
          mode_low_r <= reg_wdata[BIT_FLAG_MODE_LOW];
        end
      end
      if (rx_done_pulse) begin
        ctrl_r[BIT_RDONE] <= 1'b1;
        if (mode[1]) begin
          // An early done at the last data bit sees the ninth bit on the pin, not yet shifted.
          ctrl_r[BIT_RX_NINTH] <= (rx_state_r == UAR_DATA) ? rxd : rx_shift_r[8];
        end
      end
      // The stop bit arrives after an early done, so it is stored at its own sample.
      if ((rx_state_r == UAR_STOP) && rx_tick && (mode == MODE_UART8) && !filter_on) begin
        ctrl_r[BIT_RX_NINTH] <= rxd;
      end
      if (tx_done_pulse) begin
        ctrl_r[BIT_TDONE] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      frame_err_r <= 1'b0;
    end else if (frame_err_pulse) begin
      frame_err_r <= 1'b1;
    end else if (wr_ctrl && fsel_r) begin
      frame_err_r <= reg_wdata[BIT_FLAG_MODE_LOW];
    end
  end

  // Byte-wide registers only: no bit-level write path exists.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      node_address_r      <= ADDR_RESET;
      node_address_mask_r <= MASK_RESET;
      fsel_r              <= 1'b0;
      div_r               <= DIV_RESET;
      irq_mask_r          <= 3'h0;
    end else if (reg_wr) begin
      if (hit(reg_addr, NODE_ADDRESS_ADDR)) node_address_r <= reg_wdata;
      if (hit(reg_addr, NODE_ADDRESS_MASK_ADDR)) node_address_mask_r <= reg_wdata;
      if (hit(reg_addr, FRAMING_CTRL_ADDR)) fsel_r <= reg_wdata[BIT_FSEL];
      if (hit(reg_addr, BAUD_DIV_ADDR)) div_r <= reg_wdata;
      if (hit(reg_addr, IRQ_MASK_ADDR)) irq_mask_r <= reg_wdata[2:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_r <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if ((i == IRQ_RX && rx_done_pulse) || (i == IRQ_TX && tx_done_pulse) ||
            (i == IRQ_FRAME && frame_err_pulse)) begin
          irq_stat_r[i] <= 1'b1;
        end else if (reg_wr && hit(reg_addr, IRQ_STATUS_ADDR) && reg_wdata[i]) begin
          irq_stat_r[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // Receiver: samples at mid-bit of each divided bit period.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rx_state_r <= UAR_IDLE;
      rx_cnt_r   <= 8'h00;
      rx_bit_r   <= 4'h0;
      rx_shift_r <= 9'h000;
      rx_data_r  <= 8'h00;
    end else begin
      rx_cnt_r <= rx_tick ? div_r : rx_cnt_r - 8'h01;
      case (rx_state_r)
        UAR_IDLE: begin
          if (ctrl_r[BIT_REN] && !rxd) begin
            rx_state_r <= UAR_START;
            rx_cnt_r   <= {1'b0, div_r[7:1]};
          end
        end
        UAR_START: begin
          if (rx_tick) begin
            rx_state_r <= rxd ? UAR_IDLE : UAR_DATA;
            rx_bit_r   <= 4'h0;
          end
        end
        UAR_DATA: begin
          if (rx_tick) begin
            rx_shift_r <= {rxd, rx_shift_r[8:1]};
            if (rx_bit_r == 4'h7 && !mode[1]) rx_shift_r <= {1'b0, rxd, rx_shift_r[8:2]};
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == data_bits - 4'h1) begin
              rx_state_r <= (mode == MODE_SHIFT) ? UAR_IDLE : UAR_STOP;
            end
          end
        end
        UAR_STOP: begin
          if (rx_tick) begin
            rx_state_r <= UAR_IDLE;
            if (rx_done_pulse || !filter_on) rx_data_r <= rx_shift_r[7:0];
          end
        end
        default: rx_state_r <= UAR_IDLE;
      endcase
    end
  end

  // Transmitter: a write to the data register starts a frame.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tx_state_r <= UAR_IDLE;
      tx_cnt_r   <= 8'h00;
      tx_bit_r   <= 4'h0;
      tx_shift_r <= 9'h1FF;
      txd        <= 1'b1;
    end else begin
      tx_cnt_r <= tx_tick ? div_r : tx_cnt_r - 8'h01;
      case (tx_state_r)
        UAR_IDLE: begin
          txd <= 1'b1;
          if (reg_wr && hit(reg_addr, SERIAL_DATA_ADDR)) begin
            tx_shift_r <= {ctrl_r[BIT_TX_NINTH], reg_wdata};
            tx_state_r <= UAR_START;
            tx_cnt_r   <= div_r;
            txd        <= (mode == MODE_SHIFT) ? reg_wdata[0] : 1'b0;
            tx_bit_r   <= 4'h0;
            if (mode == MODE_SHIFT) tx_state_r <= UAR_DATA;
          end
        end
        UAR_START: begin
          if (tx_tick) begin
            tx_state_r <= UAR_DATA;
            txd        <= tx_shift_r[0];
          end
        end
        UAR_DATA: begin
          if (tx_tick) begin
            tx_bit_r <= tx_bit_r + 4'h1;
            if (tx_bit_r == data_bits - 4'h1) begin
              tx_state_r <= (mode == MODE_SHIFT) ? UAR_IDLE : UAR_STOP;
              txd        <= 1'b1;
            end else begin
              txd        <= tx_shift_r[tx_bit_r + 4'h1];
            end
          end
        end
        UAR_STOP: begin
          if (tx_tick) tx_state_r <= UAR_IDLE;
        end
        default: tx_state_r <= UAR_IDLE;
      endcase
    end
  end

  // Read data valid the cycle after the read strobe; unmapped reads give zero.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        SERIAL_CONTROL_ADDR:    reg_rdata <= {fsel_r ? frame_err_r : mode_low_r, ctrl_r[6:0]};
        SERIAL_DATA_ADDR:       reg_rdata <= rx_data_r;
        NODE_ADDRESS_ADDR:      reg_rdata <= node_address_r;
        NODE_ADDRESS_MASK_ADDR: reg_rdata <= node_address_mask_r;
        FRAMING_CTRL_ADDR:      reg_rdata <= {7'h00, fsel_r};
        IRQ_STATUS_ADDR:        reg_rdata <= {5'h00, irq_stat_r};
        IRQ_MASK_ADDR:          reg_rdata <= {5'h00, irq_mask_r};
        BAUD_DIV_ADDR:          reg_rdata <= div_r;
        default:                reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

/* verification/uar_props.sv */
// Checker of bus and pin relations of the serial port with address match.
`timescale 1ns/10ps
`default_nettype none
module uar_props
  import uar_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       rxd,
  input wire logic       txd,
  input wire logic       irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside answer");
  AST_UNMAPPED_ZERO: assert property ((reg_rd && reg_addr == 8'h00) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_ADDR_RW: assert property ((reg_wr && reg_addr == NODE_ADDRESS_ADDR) ##2
    (reg_rd && reg_addr == NODE_ADDRESS_ADDR) |=> reg_rdata == $past(reg_wdata, 3))
    else $error("address readback wrong");
  AST_MASK_RW: assert property ((reg_wr && reg_addr == NODE_ADDRESS_MASK_ADDR) ##2
    (reg_rd && reg_addr == NODE_ADDRESS_MASK_ADDR) |=> reg_rdata == $past(reg_wdata, 3))
    else $error("mask readback wrong");
  AST_CTRL_RW: assert property ((reg_wr && reg_addr == SERIAL_CONTROL_ADDR) ##2
    (reg_rd && reg_addr == SERIAL_CONTROL_ADDR) |=>
    (reg_rdata & 8'h78) == ($past(reg_wdata, 3) & 8'h78))
    else $error("control readback wrong");
  AST_IRQ_MASKED: assert property ((reg_wr && reg_addr == IRQ_MASK_ADDR && reg_wdata == 8'h00)
    |-> ##2 !irq)
    else $error("interrupt while masked");
  AST_RESET_IDLE: assert property ($rose(rst_b) |-> (txd && !irq && reg_rdata == 8'h00))
    else $error("outputs not idle after reset");
  // A start bit spans a whole bit period, so a short low pulse is a broken frame.
  AST_TXD_BIT: assert property ($fell(txd) |-> !txd [*8])
    else $error("transmit bit too short");
  cover property ($rose(irq));
  cover property ($fell(txd));
  cover property (reg_rd && reg_addr == IRQ_STATUS_ADDR);
endmodule
bind uar_top uar_props u_props (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rxd(rxd), .txd(txd), .irq(irq));
`default_nettype wire

/* verification/uar_node_model.sv */
// Serial node on the far side that sends frames into the receive line.
`timescale 1ns/10ps
`default_nettype none
module uar_node_model #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic clk_sys,
  output var logic  rxd
);
  int bit_no = 0;
  initial rxd = 1'b1;
  task automatic send(input logic [8:0] d, input int nb, input logic s);
    for (int i = 0; i < nb + 2; i++) begin
      bit_no = i;
      rxd <= (i == 0) ? 1'b0 : (i > nb) ? s : d[i - 1];
      repeat (BIT_CLKS) @(posedge clk_sys);
    end
    rxd <= 1'b1;
    bit_no = 0;
  endtask
endmodule
`default_nettype wire

/* verification/tb_uart_addr_recog_frame_err.sv */
// Self-checking bench for the serial port with address match and framing flag.
`timescale 1ns/10ps
`default_nettype none
module tb_uart_addr_recog_frame_err;
  import uar_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic [7:0]  rv;
  logic        rxd;
  logic        txd;
  logic        irq;
  int          errors = 0;
  int          checked = 0;
  // Control, bit count, data, stop, compare mask and expected control bits.
  logic [43:0] tab [6] = '{44'h70_8_053_1_01_01, 44'h70_8_063_1_01_00, 44'h70_8_05F_0_01_00,
                           44'hF0_9_153_1_05_05, 44'hF0_9_053_1_01_00, 44'h50_8_063_1_05_05};
  logic [15:0] rtab [5] = '{16'hA9_00, 16'hB9_00, 16'h98_00, 16'hC4_0F, 16'h00_00};
  always #2.5 clk_sys = ~clk_sys;
  uar_top u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd(rxd), .txd(txd), .irq(irq));
  uar_node_model #(.BIT_CLKS(int'(DIV_RESET) + 1)) u_node (.clk_sys(clk_sys), .rxd(rxd));
  task automatic end_of_test();
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // The answer stands for one cycle only, so it is taken just after the edge.
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic rx(input logic [8:0] d, input int nb, input logic s);
    u_node.send(d, nb, s);
    repeat (4) @(posedge clk_sys);
  endtask
  initial begin
    repeat (10000) @(posedge clk_sys);
    errors++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    foreach (rtab[i]) begin
      rd(rtab[i][15:8]);
      cmp8(rv, rtab[i][7:0]);
    end
    wr(NODE_ADDRESS_ADDR, 8'h5A);
    rd(NODE_ADDRESS_ADDR);
    cmp8(rv, 8'h5A);
    wr(NODE_ADDRESS_MASK_ADDR, 8'hF0);
    rd(NODE_ADDRESS_MASK_ADDR);
    cmp8(rv, 8'hF0);
    wr(FRAMING_CTRL_ADDR, 8'h01);
    wr(IRQ_MASK_ADDR, 8'h07);
    wr(SERIAL_CONTROL_ADDR, 8'h50);
    rx(9'h0A5, 8, 1'b0);
    rd(SERIAL_CONTROL_ADDR);
    cmp8({6'h00, rv[7], irq}, 8'h03);
    rx(9'h03C, 8, 1'b1);
    rd(SERIAL_CONTROL_ADDR);
    cmp8(rv & 8'h80, 8'h80);
    rd(SERIAL_DATA_ADDR);
    cmp8(rv, 8'h3C);
    wr(IRQ_STATUS_ADDR, 8'h07);
    wr(SERIAL_CONTROL_ADDR, 8'h50);
    rd(SERIAL_CONTROL_ADDR);
    cmp8({2'h0, rv[7:3], irq}, 8'h14);
    for (int f = 1; f >= 0; f--) begin
      wr(FRAMING_CTRL_ADDR, 8'(f));
      wr(SERIAL_CONTROL_ADDR, 8'h50);
      fork
        u_node.send(9'h011, 8, 1'b1);
        begin
          wait (u_node.bit_no == 8);
          repeat (10) @(posedge clk_sys);
          rd(SERIAL_CONTROL_ADDR);
          cmp8(rv & 8'h01, 8'(1 - f));
        end
      join
    end
    foreach (tab[i]) begin
      wr(SERIAL_CONTROL_ADDR, tab[i][43:36]);
      rx(tab[i][28:20], int'(tab[i][35:32]), tab[i][16]);
      rd(SERIAL_CONTROL_ADDR);
      cmp8(rv & tab[i][15:8], tab[i][7:0]);
    end
    wr(SERIAL_CONTROL_ADDR, 8'h50);
    wr(SERIAL_DATA_ADDR, 8'hA5);
    @(negedge clk_sys);
    cmp8({7'h00, txd}, 8'h00);
    repeat (130) @(posedge clk_sys);
    rd(SERIAL_CONTROL_ADDR);
    cmp8(rv & 8'h02, 8'h00);
    repeat (16) @(posedge clk_sys);
    rd(SERIAL_CONTROL_ADDR);
    cmp8({6'h00, rv[1], irq}, 8'h03);
    wr(IRQ_MASK_ADDR, 8'h00);
    rd(IRQ_STATUS_ADDR);
    cmp8({6'h00, rv[1], irq}, 8'h02);
    end_of_test();
  end
endmodule
`default_nettype wire
